/* File: prio_pkg.sv */
// constants for the interrupt priority and dispatch block
// assumes a single 10 MHz clock domain and a plain register port
package prio_pkg;
    localparam int         NUM_VEC        = 256;
    localparam int         VEC_W          = 8;
    localparam int         CLASS_W        = 4;
    localparam logic [7:0] FIRST_USER_VEC = 8'h10;
    localparam logic [7:0] NO_VECTOR      = 8'h00;
    localparam logic [7:0] TPR_RESET      = 8'h00;
    localparam int         ADDR_W         = 8;
    // register offsets (word index on the plain port)
    localparam logic [7:0] OFF_TASK_PRIO  = 8'h00;
    localparam logic [7:0] OFF_PROC_PRIO  = 8'h01;
    localparam logic [7:0] OFF_DONE       = 8'h02;
    localparam logic [7:0] OFF_CTRL       = 8'h03;
    localparam logic [7:0] OFF_STATUS     = 8'h04;
    localparam logic [7:0] OFF_REQ_BASE   = 8'h10;
    localparam logic [7:0] OFF_SVC_BASE   = 8'h18;
    localparam logic [7:0] OFF_TRIG_BASE  = 8'h20;
    localparam int         CTRL_EXT_BIT   = 0;
    localparam int         CTRL_OLD_BIT   = 1;
    localparam int         CLASS_LIMIT    = 2;
    // bypass delivery kinds
    localparam logic [2:0] DK_NMI         = 3'h0;
    localparam logic [2:0] DK_SYS_MGMT    = 3'h1;
    localparam logic [2:0] DK_INIT        = 3'h2;
    localparam logic [2:0] DK_EXTERNAL    = 3'h3;
    localparam logic [2:0] DK_STARTUP     = 3'h4;
    localparam logic [2:0] DK_INIT_DEASRT = 3'h5;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_OFFER = 3'b010,
        ST_DONE  = 3'b100
    } disp_state_t;
endpackage : prio_pkg

/* File: pick_if.sv */
// carries one 256-bit bitmap into the priority picker and the answer out
// assumes picker and user share one clock-free combinational path
`timescale 1ns/1ns
`default_nettype none
interface pick_if;
    logic [255:0] bits;
    logic         any;
    logic [7:0]   top;
    modport user (output bits, input any, input top);
    modport picker (input bits, output any, output top);
endinterface : pick_if
`default_nettype wire

/* File: prio_pick.sv */
// finds the highest set bit of a 256-bit bitmap
// assumes caller masks reserved vectors itself
`timescale 1ns/1ns
`default_nettype none
module prio_pick
    import prio_pkg::*;
(
    pick_if.picker p
);
    // higher vector wins: class in upper nibble, rank in lower
    always_comb begin
        p.any = 1'b0;
        p.top = NO_VECTOR;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (p.bits[i]) begin
                p.any = 1'b1;
                p.top = VEC_W'(i);
            end
        end
    end
endmodule : prio_pick
`default_nettype wire

/* File: interrupt_priority_dispatch.sv */
// request/in-service queueing, priority and dispatch for one core
// assumes synchronous inputs and a single-cycle register port
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_dispatch
    import prio_pkg::*;
#(
    parameter int NVEC = NUM_VEC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              fix_valid,
    input  wire logic [7:0]        fix_vector,
    input  wire logic              fix_level,
    output logic                   fix_reject,
    input  wire logic              byp_valid,
    input  wire logic [2:0]        byp_kind,
    output logic                   byp_out_valid,
    output logic      [2:0]        byp_out_kind,
    input  wire logic              core_ready,
    output logic                   core_int_valid,
    output logic      [7:0]        core_int_vector,
    output logic                   io_done_msg,
    output logic      [7:0]        io_done_vector,
    output logic                   gp_fault
);
    logic [NVEC-1:0] req_r, req_nxt;
    logic [NVEC-1:0] svc_r, svc_nxt;
    logic [NVEC-1:0] trig_r, trig_nxt;
    logic [7:0]      tpr_r, tpr_nxt;
    logic [7:0]      ppr_r, ppr_nxt;
    logic [1:0]      ctrl_r, ctrl_nxt;
    logic [31:0]     rdata_r, rdata_nxt;
    logic            rej_r, rej_nxt;
    logic            byp_r, byp_nxt;
    logic [2:0]      bkind_r, bkind_nxt;
    logic            civ_r, civ_nxt;
    logic [7:0]      cvec_r, cvec_nxt;
    logic            iom_r, iom_nxt;
    logic [7:0]      iov_r, iov_nxt;
    logic            gp_r, gp_nxt;
    disp_state_t     st_r, st_nxt;

    pick_if req_p ();
    pick_if svc_p ();
    prio_pick u_req_pick (.p(req_p));
    prio_pick u_svc_pick (.p(svc_p));

    logic [NVEC-1:0] user_mask;
    logic [15:0]     class_cnt_ok;
    logic            done_wr;
    logic [7:0]      top_in_service_vector;
    logic [7:0]      pend_vec;
    logic            pend_ok;

    genvar g;
    generate
        for (g = 0; g < NVEC; g++) begin : g_mask
            assign user_mask[g] = (g >= int'(FIRST_USER_VEC));
        end
        // older variant: count queued entries per class across both maps
        for (g = 0; g < 16; g++) begin : g_cls
            logic [5:0] cnt;
            always_comb begin
                cnt = 6'h00;
                for (int k = 0; k < 16; k++) begin
                    cnt = cnt + 6'(req_r[g*16+k]) + 6'(svc_r[g*16+k]);
                end
            end
            assign class_cnt_ok[g] = (cnt < 6'(CLASS_LIMIT));
        end
    endgenerate

    assign req_p.bits = req_r & user_mask;
    assign svc_p.bits = svc_r & user_mask;
    assign top_in_service_vector       = svc_p.any ? svc_p.top : NO_VECTOR;
    assign pend_vec   = req_p.top;
    // class vs processor priority nibble; covers threshold gating too
    assign pend_ok    = req_p.any
                        && (pend_vec[7:4] > ppr_r[7:4]);
    assign done_wr    = reg_wr && (reg_addr == OFF_DONE);

    // processor priority, recomputed every cycle from live state
    always_comb begin
        if (tpr_r[7:4] >= top_in_service_vector[7:4]) begin
            ppr_nxt = tpr_r;
        end else begin
            ppr_nxt = {top_in_service_vector[7:4], 4'h0};
        end
    end

    always_comb begin
        req_nxt   = req_r;
        svc_nxt   = svc_r;
        trig_nxt  = trig_r;
        tpr_nxt   = tpr_r;
        ctrl_nxt  = ctrl_r;
        rej_nxt   = 1'b0;
        byp_nxt   = 1'b0;
        bkind_nxt = bkind_r;
        civ_nxt   = 1'b0;
        cvec_nxt  = cvec_r;
        iom_nxt   = 1'b0;
        iov_nxt   = iov_r;
        gp_nxt    = 1'b0;
        st_nxt    = st_r;

        if (reg_wr && reg_addr == OFF_TASK_PRIO) begin
            tpr_nxt = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == OFF_CTRL) begin
            ctrl_nxt = reg_wdata[1:0];
        end

        // service-done: retire top in-service entry
        if (done_wr) begin
            if (ctrl_r[CTRL_EXT_BIT] && reg_wdata != 32'h0) begin
                gp_nxt = 1'b1;
            end else if (svc_p.any) begin
                svc_nxt[svc_p.top] = 1'b0;
                if (trig_r[svc_p.top]) begin
                    iom_nxt = 1'b1;
                    iov_nxt = svc_p.top;
                end
            end
        end

        // dispatch: core ready moves top eligible request into service
        unique case (st_r)
            ST_IDLE: begin
                if (pend_ok && core_ready) begin
                    req_nxt[pend_vec] = 1'b0;
                    svc_nxt[pend_vec] = 1'b1;
                    civ_nxt  = 1'b1;
                    cvec_nxt = pend_vec;
                    st_nxt   = ST_DONE;
                end
            end
            ST_OFFER: begin
                st_nxt = ST_IDLE;
            end
            ST_DONE: begin
                // one cycle gap lets processor priority settle
                st_nxt = ST_IDLE;
            end
        endcase

        // acceptance after dispatch so a new arrival re-sets its bit
        if (fix_valid) begin
            if (fix_vector < FIRST_USER_VEC) begin
                rej_nxt = 1'b1;
            end else if (ctrl_r[CTRL_OLD_BIT]
                         && !class_cnt_ok[fix_vector[7:4]]
                         && !req_r[fix_vector]) begin
                rej_nxt = 1'b1;
            end else begin
                req_nxt[fix_vector]  = 1'b1;
                trig_nxt[fix_vector] = fix_level;
            end
        end

        if (byp_valid) begin
            byp_nxt   = 1'b1;
            bkind_nxt = byp_kind;
        end
    end

    // register read, data in the following cycle
    always_comb begin
        rdata_nxt = 32'h0;
        if (reg_rd) begin
            if (reg_addr == OFF_TASK_PRIO) begin
                rdata_nxt = {24'h0, tpr_r};
            end else if (reg_addr == OFF_PROC_PRIO) begin
                rdata_nxt = {24'h0, ppr_r};
            end else if (reg_addr == OFF_CTRL) begin
                rdata_nxt = {30'h0, ctrl_r};
            end else if (reg_addr == OFF_STATUS) begin
                rdata_nxt = {16'h0, top_in_service_vector, 7'h0, civ_r};
            end else if (reg_addr[7:3] == OFF_REQ_BASE[7:3]) begin
                rdata_nxt = req_r[reg_addr[2:0]*32 +: 32];
            end else if (reg_addr[7:3] == OFF_SVC_BASE[7:3]) begin
                rdata_nxt = svc_r[reg_addr[2:0]*32 +: 32];
            end else if (reg_addr[7:3] == OFF_TRIG_BASE[7:3]) begin
                rdata_nxt = trig_r[reg_addr[2:0]*32 +: 32];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_r   <= '0;
            svc_r   <= '0;
            trig_r  <= '0;
            tpr_r   <= TPR_RESET;
            ppr_r   <= TPR_RESET;
            ctrl_r  <= 2'h0;
            rdata_r <= 32'h0;
            rej_r   <= 1'b0;
            byp_r   <= 1'b0;
            bkind_r <= DK_NMI;
            civ_r   <= 1'b0;
            cvec_r  <= NO_VECTOR;
            iom_r   <= 1'b0;
            iov_r   <= NO_VECTOR;
            gp_r    <= 1'b0;
            st_r    <= ST_IDLE;
        end else begin
            req_r   <= req_nxt;
            svc_r   <= svc_nxt;
            trig_r  <= trig_nxt;
            tpr_r   <= tpr_nxt;
            ppr_r   <= ppr_nxt;
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            rej_r   <= rej_nxt;
            byp_r   <= byp_nxt;
            bkind_r <= bkind_nxt;
            civ_r   <= civ_nxt;
            cvec_r  <= cvec_nxt;
            iom_r   <= iom_nxt;
            iov_r   <= iov_nxt;
            gp_r    <= gp_nxt;
            st_r    <= st_nxt;
        end
    end

    assign reg_rdata       = rdata_r;
    assign fix_reject      = rej_r;
    assign byp_out_valid   = byp_r;
    assign byp_out_kind    = bkind_r;
    assign core_int_valid  = civ_r;
    assign core_int_vector = cvec_r;
    assign io_done_msg     = iom_r;
    assign io_done_vector  = iov_r;
    assign gp_fault        = gp_r;
endmodule : interrupt_priority_dispatch
`default_nettype wire

/* File: core_model.sv */
// core on the far side: takes a dispatch, then is busy a few cycles
// assumes the bench drives en (interrupts enabled) after a clock edge
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic int_valid,
    output logic      ready
);
    logic [1:0] busy_r;
    // slow taker: a dispatch costs three cycles before the next offer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            busy_r <= 2'h0;
        else if (int_valid)
            busy_r <= 2'h3;
        else if (busy_r != 2'h0)
            busy_r <= busy_r - 2'h1;
    end
    assign ready = en && (busy_r == 2'h0);
endmodule : core_model
`default_nettype wire

/* File: ipd_sva.sv */
// port checker for the priority dispatch block
// assumes one clock domain, rst_n asynchronous active low
`timescale 1ns/1ns
`default_nettype none
module ipd_sva import prio_pkg::*; (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              fix_valid,
    input wire logic [7:0]        fix_vector,
    input wire logic              fix_reject,
    input wire logic              byp_valid,
    input wire logic [2:0]        byp_kind,
    input wire logic              byp_out_valid,
    input wire logic [2:0]        byp_out_kind,
    input wire logic              core_ready,
    input wire logic              core_int_valid,
    input wire logic [7:0]        core_int_vector,
    input wire logic              io_done_msg,
    input wire logic              gp_fault
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd: assert property (p_rd) else $error("rdata not idle");
    property p_gap; core_int_valid |=> !core_int_valid; endproperty
    a_gap: assert property (p_gap) else $error("dispatch b2b");
    property p_rdy; core_int_valid |-> $past(core_ready); endproperty
    a_rdy: assert property (p_rdy) else $error("core not ready");
    property p_usr;
        core_int_valid |-> core_int_vector >= FIRST_USER_VEC;
    endproperty
    a_usr: assert property (p_usr) else $error("reserved vector");
    property p_byp;
        byp_valid |=> byp_out_valid && byp_out_kind == $past(byp_kind);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass lost");
    property p_gp;
        gp_fault |-> $past(reg_wr && reg_addr == OFF_DONE && |reg_wdata);
    endproperty
    a_gp: assert property (p_gp) else $error("stray fault");
    property p_low;
        fix_valid && fix_vector < FIRST_USER_VEC |=> fix_reject;
    endproperty
    a_low: assert property (p_low) else $error("low vec taken");
    property p_done;
        io_done_msg |-> $past(reg_wr && reg_addr == OFF_DONE);
    endproperty
    a_done: assert property (p_done) else $error("stray message");
endmodule : ipd_sva
bind interrupt_priority_dispatch ipd_sva i_sva (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fix_valid(fix_valid),
    .fix_vector(fix_vector), .fix_reject(fix_reject),
    .byp_valid(byp_valid), .byp_kind(byp_kind),
    .byp_out_valid(byp_out_valid), .byp_out_kind(byp_out_kind),
    .core_ready(core_ready), .core_int_valid(core_int_valid),
    .core_int_vector(core_int_vector), .io_done_msg(io_done_msg),
    .gp_fault(gp_fault));
`default_nettype wire

/* File: interrupt_priority_dispatch_tb_top.sv */
// bench for the priority dispatch block
// assumes core_model stands in for the core
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_dispatch_tb_top import prio_pkg::*;;
    logic        clk, rst_n, reg_wr, reg_rd, fix_valid, fix_level, en;
    logic        byp_valid, core_ready, core_int_valid, io_done_msg;
    logic        fix_reject, byp_out_valid, gp_fault;
    logic [7:0]  reg_addr, fix_vector, core_int_vector, io_done_vector;
    logic [31:0] reg_wdata, reg_rdata;
    logic [2:0]  byp_kind, byp_out_kind;
    int          err_total, checked, cyc, n_int, n_done, n_gp, n_rej;
    interrupt_priority_dispatch i_dut (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fix_valid(fix_valid),
        .fix_vector(fix_vector), .fix_level(fix_level),
        .fix_reject(fix_reject), .byp_valid(byp_valid),
        .byp_kind(byp_kind), .byp_out_valid(byp_out_valid),
        .byp_out_kind(byp_out_kind), .core_ready(core_ready),
        .core_int_valid(core_int_valid), .core_int_vector(core_int_vector),
        .io_done_msg(io_done_msg), .io_done_vector(io_done_vector),
        .gp_fault(gp_fault));
    core_model i_core (.clk(clk), .rst_n(rst_n), .en(en),
        .int_valid(core_int_valid), .ready(core_ready));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulses are counted so that no check hangs on one exact cycle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_int <= n_int + int'(core_int_valid);
        n_done <= n_done + int'(io_done_msg);
        n_gp <= n_gp + int'(gp_fault);
        n_rej <= n_rej + int'(fix_reject);
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic idle(int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(nm, reg_rdata, e);
    endtask : rd
    task automatic fx(logic [7:0] v, logic l);
        @(posedge clk);
        fix_valid <= 1'b1;
        fix_vector <= v;
        fix_level <= l;
        @(posedge clk);
        fix_valid <= 1'b0;
    endtask : fx
    task automatic wint(string nm, int k, logic [7:0] v);
        for (int i = 0; i < 40 && n_int < k; i++) @(posedge clk);
        chk("dispatches", n_int, k);
        chk(nm, core_int_vector, v);
    endtask : wint
    task automatic byp(logic [2:0] k);
        @(posedge clk);
        byp_valid <= 1'b1;
        byp_kind <= k;
        @(posedge clk);
        byp_valid <= 1'b0;
        @(negedge clk);
        chk("bypass", {byp_out_valid, byp_out_kind}, {1'b1, k});
    endtask : byp
    task automatic t_regs();
        rd("thr reset", OFF_TASK_PRIO, 32'h0);
        rd("prio reset", OFF_PROC_PRIO, 32'h0);
        wr(OFF_TASK_PRIO, 32'h35);
        wr(OFF_PROC_PRIO, 32'h77);
        rd("thr", OFF_TASK_PRIO, 32'h35);
        rd("prio ro", OFF_PROC_PRIO, 32'h35);
        rd("unmapped", 8'h80, 32'h0);
        wr(OFF_TASK_PRIO, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_disp();
        fx(8'h41, 1'b1);
        fx(8'h4F, 1'b0);
        fx(8'h20, 1'b0);
        rd("req w2", 8'h12, 32'h8002);
        rd("req w1", 8'h11, 32'h1);
        rd("trig w2", 8'h22, 32'h2);
        @(posedge clk);
        en <= 1'b1;
        wint("top", 1, 8'h4F);
        rd("svc w2", 8'h1A, 32'h8000);
        rd("prio", OFF_PROC_PRIO, 32'h40);
        wr(OFF_DONE, 32'h0);
        wint("next", 2, 8'h41);
        wr(OFF_DONE, 32'h0);
        idle(2);
        chk("msgs", n_done, 1);
        chk("msg vec", io_done_vector, 8'h41);
        wint("class2", 3, 8'h20);
        fx(8'h90, 1'b0);
        wint("preempt", 4, 8'h90);
        wr(OFF_DONE, 32'h0);
        wr(OFF_DONE, 32'h0);
        wr(OFF_DONE, 32'h0);
        idle(4);
        chk("edge msgs", n_done, 1);
        chk("idle", n_int, 4);
        rd("svc w1", 8'h19, 32'h0);
        $display("t_disp done");
    endtask : t_disp
    task automatic t_thr();
        wr(OFF_TASK_PRIO, 32'h5A);
        fx(8'h50, 1'b0);
        idle(10);
        chk("held", n_int, 4);
        rd("prio thr", OFF_PROC_PRIO, 32'h5A);
        wr(OFF_TASK_PRIO, 32'h4F);
        wint("above", 5, 8'h50);
        wr(OFF_DONE, 32'h0);
        wr(OFF_TASK_PRIO, 32'hF0);
        fx(8'hFF, 1'b0);
        for (int k = 0; k < 6; k++) byp(3'(k));
        idle(5);
        chk("all held", n_int, 5);
        wr(OFF_TASK_PRIO, 32'h0);
        wint("open", 6, 8'hFF);
        wr(OFF_DONE, 32'h0);
        $display("t_thr done");
    endtask : t_thr
    task automatic t_ext();
        wr(OFF_CTRL, 32'h1);
        wr(OFF_DONE, 32'h5);
        idle(2);
        chk("fault", n_gp, 1);
        wr(OFF_DONE, 32'h0);
        idle(2);
        chk("no fault", n_gp, 1);
        wr(OFF_CTRL, 32'h2);
        en <= 1'b0;
        fx(8'h61, 1'b0);
        fx(8'h62, 1'b0);
        fx(8'h63, 1'b0);
        idle(2);
        chk("third", n_rej, 1);
        fx(8'h61, 1'b0);
        idle(2);
        chk("merge", n_rej, 1);
        fx(8'h05, 1'b0);
        idle(2);
        chk("reserved", n_rej, 2);
        $display("t_ext done");
    endtask : t_ext
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst_n, reg_wr, reg_rd, fix_valid, fix_level, byp_valid, en} = '0;
        {reg_addr, fix_vector, reg_wdata, byp_kind} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_disp();
        t_thr();
        t_ext();
        tally_and_finish();
    end
endmodule : interrupt_priority_dispatch_tb_top
`default_nettype wire
